// ==== verilog/deeac_pkg.sv ====
// What this block does
// - Control register holds five low bits; upper bits read as zero.
// - Software may set read and write start bits but never clear them.
// - Hardware clears read or write start bit when that operation ends.
// - A write starts only while the write enable gate is set.
// - Write enable gate is clear after power-up.
// - Pin or watchdog reset during a write sets the write abort flag.
// - After such an abort the data and address registers stay unchanged.
// - Write completion sets the done flag in the peripheral flag register.
// - Hardware never clears the done flag; only software does.
// - Unlock register has no storage and always reads as zero.
// - Unlock register writes serve only the write launch sequence.
// - Data register holds the 8-bit byte read or to be written.
// - Only the low seven address bits select one of 128 bytes.
// - A byte write erases the location before programming it.
// - An internal timer sets write length; write bit stays set meanwhile.
package deeac_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned ERASE_TIME_US = 2000;
   localparam int unsigned PROG_TIME_US = 2000;
   localparam int unsigned ERASE_CYCLES_DEF =
      ERASE_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PROG_CYCLES_DEF =
      PROG_TIME_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W = 24;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned MEM_AW = 7;
   localparam int unsigned MEM_DEPTH = 128;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] OFF_CTL = 8'h00;
   localparam logic [7:0] OFF_UNLOCK = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_ADDR = 8'h0C;
   localparam logic [7:0] OFF_FLAG = 8'h10;
   localparam logic [7:0] OFF_CLR = 8'h14;
   localparam logic [7:0] OFF_IEN = 8'h18;
   localparam int unsigned CTL_RD = 0;
   localparam int unsigned CTL_WR = 1;
   localparam int unsigned CTL_WRITE_ENABLE_GATE = 2;
   localparam int unsigned CTL_WRITE_ABORT_FLAG = 3;
   localparam int unsigned CTL_ARMED = 4;
   localparam int unsigned CTL_BITS = 5;
   localparam int unsigned FLG_WDONE = 0;
   localparam int unsigned FLG_RDONE = 1;
   localparam int unsigned FLG_ABORT = 2;
   localparam int unsigned FLG_BITS = 3;
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [2:0] FLAG_RESET = 3'h0;
   localparam logic [2:0] IEN_RESET = 3'h0;
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_ERASE, ST_PROG}
      deeac_state_type;
   typedef enum logic [1:0] {UNL_NONE, UNL_FIRST, UNL_ARMED}
      deeac_unlock_type;
endpackage

// ==== verilog/deeac_mem.sv ====
`timescale 1ns/10ps
module deeac_mem
#(
   parameter int unsigned DW = 8,
   parameter int unsigned AW = 7
)
(
   input wire logic clk,
   input wire logic we,
   input wire logic re,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);
   // No reset: array contents are nonvolatile in spirit
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      if (re)
      begin
         rdata <= mem[addr];
      end
   end
endmodule

// ==== verilog/deeac_top.sv ====
`timescale 1ns/10ps
module deeac_top
#(
   parameter int unsigned ERASE_CYCLES = deeac_pkg::ERASE_CYCLES_DEF,
   parameter int unsigned PROG_CYCLES = deeac_pkg::PROG_CYCLES_DEF
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic external_reset_pin_n,
   input wire logic watchdog_reset,
   output logic irq
);
   import deeac_pkg::*;

   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
      reg_hit = (a[7:2] == off[7:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset pins come from outside the clock domain
   logic [1:0] ext_sync_q;
   logic [1:0] wdt_sync_q;
   logic soft_rst;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_sync_q <= 2'h3;
         wdt_sync_q <= 2'h0;
      end
      else
      begin
         ext_sync_q <= {ext_sync_q[0], external_reset_pin_n};
         wdt_sync_q <= {wdt_sync_q[0], watchdog_reset};
      end
   end

   assign soft_rst = !ext_sync_q[1] || wdt_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY
   logic acc;
   logic ph_wr_q;
   logic [7:0] ph_addr_q;
   logic [31:0] hrdata_q;
   logic ctl_wr;
   logic unl_wr;
   logic data_wr;
   logic addr_wr;
   logic clr_wr;
   logic ien_wr;

   deeac_state_type state_q;
   deeac_unlock_type unlock_q;
   logic [CNT_W-1:0] cnt_q;
   logic rd_q;
   logic wr_q;
   logic write_enable_gate_q;
   logic write_abort_flag_q;
   logic [7:0] data_q;
   logic [7:0] addr_q;
   logic [FLG_BITS-1:0] flag_q;
   logic [FLG_BITS-1:0] ien_q;
   logic writing;
   logic step_end;
   logic prog_done;
   logic mem_we;
   logic mem_re;
   logic [7:0] mem_wdata;
   logic [7:0] mem_rdata;

   assign acc = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign ctl_wr = ph_wr_q && reg_hit(ph_addr_q, OFF_CTL);
   assign unl_wr = ph_wr_q && reg_hit(ph_addr_q, OFF_UNLOCK);
   assign data_wr = ph_wr_q && reg_hit(ph_addr_q, OFF_DATA);
   assign addr_wr = ph_wr_q && reg_hit(ph_addr_q, OFF_ADDR);
   assign clr_wr = ph_wr_q && reg_hit(ph_addr_q, OFF_CLR);
   assign ien_wr = ph_wr_q && reg_hit(ph_addr_q, OFF_IEN);

   function automatic logic [31:0] read_value(input logic [7:0] a);
      read_value = 32'h0000_0000;
      if (reg_hit(a, OFF_CTL))
      begin
         read_value[CTL_BITS-1:0] = {unlock_q == UNL_ARMED, write_abort_flag_q,
            write_enable_gate_q, wr_q, rd_q};
      end
      else if (reg_hit(a, OFF_DATA))
      begin
         read_value[7:0] = data_q;
      end
      else if (reg_hit(a, OFF_ADDR))
      begin
         read_value[7:0] = addr_q;
      end
      else if (reg_hit(a, OFF_FLAG))
      begin
         read_value[FLG_BITS-1:0] = flag_q;
      end
      else if (reg_hit(a, OFF_IEN))
      begin
         read_value[FLG_BITS-1:0] = ien_q;
      end
   endfunction

   // Read data is sampled at the address phase, so a read right behind a
   // write to the same register returns the value before that write
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ph_wr_q <= 1'b0;
         ph_addr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end
      else
      begin
         ph_wr_q <= acc && hwrite;
         ph_addr_q <= haddr[7:0];
         hrdata_q <= (acc && !hwrite) ? read_value(haddr[7:0])
            : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unlock tracker: keys only count when nothing else is written between
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         unlock_q <= UNL_NONE;
      end
      else if (soft_rst)
      begin
         unlock_q <= UNL_NONE;
      end
      else if (unl_wr)
      begin
         if (hwdata[7:0] == UNLOCK_KEY1)
         begin
            unlock_q <= UNL_FIRST;
         end
         else if (unlock_q == UNL_FIRST && hwdata[7:0] == UNLOCK_KEY2)
         begin
            unlock_q <= UNL_ARMED;
         end
         else
         begin
            unlock_q <= UNL_NONE;
         end
      end
      else if (ph_wr_q)
      begin
         unlock_q <= UNL_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: read, or timed erase then program
   assign writing = (state_q == ST_ERASE) || (state_q == ST_PROG);
   assign step_end = writing && (cnt_q == '0);
   assign prog_done = step_end && (state_q == ST_PROG) && !soft_rst;
   assign mem_we = step_end && !soft_rst;
   assign mem_wdata = (state_q == ST_ERASE) ? ERASED_BYTE : data_q;
   assign mem_re = (state_q == ST_IDLE) && rd_q && !wr_q && !soft_rst;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end
      else if (soft_rst)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
            begin
               if (wr_q)
               begin
                  state_q <= ST_ERASE;
                  cnt_q <= CNT_W'(ERASE_CYCLES - 1);
               end
               else if (rd_q)
               begin
                  state_q <= ST_READ;
               end
            end
            ST_READ:
            begin
               state_q <= ST_IDLE;
            end
            ST_ERASE:
            begin
               if (cnt_q == '0)
               begin
                  state_q <= ST_PROG;
                  cnt_q <= CNT_W'(PROG_CYCLES - 1);
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            ST_PROG:
            begin
               if (cnt_q == '0)
               begin
                  state_q <= ST_IDLE;
               end
               else
               begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
         endcase
      end
   end

   deeac_mem #(.DW(DATA_W), .AW(MEM_AW)) u_mem
   (
      .clk(clk),
      .we(mem_we),
      .re(mem_re),
      .addr(addr_q[MEM_AW-1:0]),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control bits; start bits are set-only from the bus
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_q <= 1'b0;
      end
      else if (soft_rst || state_q == ST_READ)
      begin
         rd_q <= 1'b0;
      end
      else if (ctl_wr && hwdata[CTL_RD] && state_q == ST_IDLE && !wr_q)
      begin
         rd_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= 1'b0;
      end
      else if (soft_rst || prog_done)
      begin
         wr_q <= 1'b0;
      end
      else if (ctl_wr && hwdata[CTL_WR] && write_enable_gate_q && !rd_q
         && unlock_q == UNL_ARMED && state_q == ST_IDLE)
      begin
         wr_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         write_enable_gate_q <= 1'b0;
      end
      else if (soft_rst)
      begin
         write_enable_gate_q <= 1'b0;
      end
      else if (ctl_wr)
      begin
         write_enable_gate_q <= hwdata[CTL_WRITE_ENABLE_GATE];
      end
   end

   // Abort set wins over a software write in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         write_abort_flag_q <= 1'b0;
      end
      else if (soft_rst && writing)
      begin
         write_abort_flag_q <= 1'b1;
      end
      else if (ctl_wr)
      begin
         write_abort_flag_q <= hwdata[CTL_WRITE_ABORT_FLAG];
      end
   end

   // Data and address ignore the soft reset and are frozen during a write
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_q <= DATA_RESET;
      end
      else if (state_q == ST_READ)
      begin
         data_q <= mem_rdata;
      end
      else if (data_wr && !writing)
      begin
         data_q <= hwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_q <= ADDR_RESET;
      end
      else if (addr_wr && !writing && state_q != ST_READ)
      begin
         addr_q <= hwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags, write-one-to-clear, set wins
   logic [FLG_BITS-1:0] flag_set;
   logic [FLG_BITS-1:0] flag_clr;

   always_comb
   begin
      flag_set = '0;
      flag_set[FLG_WDONE] = prog_done;
      flag_set[FLG_RDONE] = (state_q == ST_READ) && !soft_rst;
      flag_set[FLG_ABORT] = soft_rst && writing;
      flag_clr = clr_wr ? hwdata[FLG_BITS-1:0] : '0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag_q <= FLAG_RESET;
      end
      else
      begin
         flag_q <= (flag_q & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ien_q <= IEN_RESET;
      end
      else if (ien_wr)
      begin
         ien_q <= hwdata[FLG_BITS-1:0];
      end
   end

   assign irq = |(flag_q & ien_q);

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   ctl_upper_zero_a: assert property ($past(acc && !hwrite)
      && reg_hit(ph_addr_q, OFF_CTL) |-> hrdata[31:CTL_BITS] == '0)
      else $error("control upper bits not zero");
   start_set_only_a: assert property ($fell(wr_q)
      |-> $past(prog_done || soft_rst))
      else $error("write bit cleared early");
   read_clear_a: assert property ($rose(rd_q) |-> ##2 !rd_q)
      else $error("read bit not cleared");
   gate_needed_a: assert property ($rose(wr_q) |-> $past(write_enable_gate_q))
      else $error("write started without gate");
   abort_flag_a: assert property (soft_rst && writing
      |=> write_abort_flag_q && flag_q[FLG_ABORT])
      else $error("abort not flagged");
   regs_kept_a: assert property (soft_rst |=> $stable(data_q)
      && $stable(addr_q))
      else $error("data or address lost on reset");
   done_flag_a: assert property (prog_done |=> flag_q[FLG_WDONE]
      && !wr_q && state_q == ST_IDLE)
      else $error("done flag not set");
   done_sticky_a: assert property (flag_q[FLG_WDONE]
      && !(clr_wr && hwdata[FLG_WDONE]) |=> flag_q[FLG_WDONE])
      else $error("done flag lost");
   unlock_zero_a: assert property ($past(acc && !hwrite)
      && reg_hit(ph_addr_q, OFF_UNLOCK) |-> hrdata == '0)
      else $error("unlock register not zero");
   write_held_a: assert property (writing |-> wr_q)
      else $error("write bit dropped mid write");
   erase_first_a: assert property ($rose(wr_q)
      |=> state_q == ST_ERASE ##1 state_q == ST_ERASE || state_q == ST_PROG)
      else $error("write skipped erase");
   unlock_seq_a: assert property ($rose(wr_q)
      |-> $past(unlock_q == UNL_ARMED))
      else $error("write without unlock");
endmodule

// ==== bench/deeac_testbench.sv ====
`timescale 1ns/10ps
module testbench;
   import deeac_pkg::*;
   // Short timer counts keep the run brief; checks poll for idle rather than use these values
   localparam int unsigned ER_C = 8;
   localparam int unsigned PR_C = 8;
   logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic external_reset_pin_n, watchdog_reset;
   logic [7:0] a, d;
   logic [7:0] exp_mem [0:127];
   logic [7:0] addrs [$];
   int mismatches, check_count, cycles, seed, n;

   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;

   deeac_top #(.ERASE_CYCLES(ER_C), .PROG_CYCLES(PR_C)) dut
   (
      .clk(clk),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .external_reset_pin_n(external_reset_pin_n),
      .watchdog_reset(watchdog_reset),
      .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] ctl_word(input logic write_enable_gate, input logic err,
      input logic wbit);
      return {27'h0000000, 1'b0, err, write_enable_gate, wbit, 1'b0};
   endfunction

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One single word transfer; returns at the edge that ends the data phase
   task automatic bus(input logic w, input logic [7:0] ad,
      input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, ad};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      bus(1'b1, ad, wd);
   endtask

   task automatic rd(input logic [7:0] ad);
      bus(1'b0, ad, 32'h00000000);
   endtask

   // Irq is combinational from flops that moved at the last edge
   task automatic chk_irq(input logic exp);
      #1;
      check("irq", {31'h00000000, irq}, {31'h00000000, exp});
   endtask

   task automatic ee_write(input logic [7:0] ad, input logic [7:0] dat);
      wr(OFF_CTL, 32'h00000004);
      wr(OFF_ADDR, {24'h000000, ad});
      wr(OFF_DATA, {24'h000000, dat});
      wr(OFF_UNLOCK, {24'h000000, UNLOCK_KEY1});
      wr(OFF_UNLOCK, {24'h000000, UNLOCK_KEY2});
      wr(OFF_CTL, 32'h00000006);
   endtask

   task automatic wait_idle();
      rd(OFF_CTL);
      for (n = 0; n < 60 && q[1:0] !== 2'b00; n++)
         rd(OFF_CTL);
      check("ctl_busy", {30'h00000000, q[1:0]}, 32'h00000000);
   endtask

   task automatic ee_read(input logic [7:0] ad);
      wr(OFF_ADDR, {24'h000000, ad});
      wr(OFF_CTL, 32'h00000005);
      wait_idle();
      rd(OFF_DATA);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      seed = 1360;
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      external_reset_pin_n = 1'b1;
      watchdog_reset = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(OFF_CTL);
      check("ctl_reset", q, ctl_word(1'b0, 1'b0, 1'b0));
      wr(OFF_UNLOCK, {24'h000000, UNLOCK_KEY1});
      rd(OFF_UNLOCK);
      check("unlock_read", q, 32'h00000000);
      rd(8'h40);
      check("unmapped", q, 32'h00000000);
      wr(OFF_CTL, 32'hFFFFFFE4);
      rd(OFF_CTL);
      check("ctl_upper", q, ctl_word(1'b1, 1'b0, 1'b0));
      // A proper write, with the interrupt enabled
      wr(OFF_IEN, 32'h00000001);
      ee_write(8'h10, 8'h5A);
      rd(OFF_CTL);
      check("wr_set", q, ctl_word(1'b1, 1'b0, 1'b1));
      wr(OFF_CTL, 32'h00000004);
      rd(OFF_CTL);
      check("wr_kept", q, ctl_word(1'b1, 1'b0, 1'b1));
      chk_irq(1'b0);
      wait_idle();
      rd(OFF_FLAG);
      check("done_flag", q, 32'h00000001);
      chk_irq(1'b1);
      repeat (20) @(posedge clk);
      rd(OFF_FLAG);
      check("done_sticky", q, 32'h00000001);
      wr(OFF_IEN, 32'h00000000);
      chk_irq(1'b0);
      wr(OFF_IEN, 32'h00000001);
      chk_irq(1'b1);
      wr(OFF_CLR, 32'h00000001);
      chk_irq(1'b0);
      rd(OFF_FLAG);
      check("done_clear", q, 32'h00000000);
      // Gate clear, then no unlock: neither may change the byte
      wr(OFF_CTL, 32'h00000000);
      wr(OFF_DATA, 32'h0000003C);
      wr(OFF_UNLOCK, {24'h000000, UNLOCK_KEY1});
      wr(OFF_UNLOCK, {24'h000000, UNLOCK_KEY2});
      wr(OFF_CTL, 32'h00000006);
      rd(OFF_CTL);
      check("gate_off", {31'h00000000, q[1]}, 32'h00000000);
      wr(OFF_CTL, 32'h00000006);
      rd(OFF_CTL);
      check("no_unlock", {31'h00000000, q[1]}, 32'h00000000);
      ee_read(8'h10);
      check("byte_kept", q, 32'h0000005A);
      rd(OFF_FLAG);
      check("rd_done", q, 32'h00000002);
      // Random bytes with corner addresses and values first
      for (int i = 0; i < 8; i++)
      begin
         a = 8'($random(seed)) & 8'h7F;
         d = 8'($random(seed));
         if (i < 2)
         begin
            a = (i == 0) ? 8'h7F : 8'h00;
            d = (i == 0) ? 8'h00 : 8'hFF;
         end
         // Read-done from earlier reads must not spoil the flag compare
         wr(OFF_CLR, 32'h00000007);
         ee_write(a, d);
         exp_mem[a] = d;
         addrs.push_back(a);
         wait_idle();
         rd(OFF_FLAG);
         check("rnd_done", q, 32'h00000001);
         wr(OFF_CLR, 32'h00000007);
      end
      // Odd entries read with the unused top address bit set
      foreach (addrs[i])
      begin
         ee_read(addrs[i] | {i[0], 7'h00});
         check("rnd_byte", q, {24'h000000, exp_mem[addrs[i]]});
      end
      // Watchdog, then pin reset, each aborting a write in progress
      for (int src = 0; src < 2; src++)
      begin
         a = 8'h22 + 8'(src);
         d = 8'hC3 ^ 8'(src);
         wr(OFF_CLR, 32'h00000007);
         ee_write(a, d);
         rd(OFF_CTL);
         check("abort_busy", {31'h00000000, q[1]}, 32'h00000001);
         if (src == 0)
            watchdog_reset <= 1'b1;
         else
            external_reset_pin_n <= 1'b0;
         repeat (4) @(posedge clk);
         watchdog_reset <= 1'b0;
         external_reset_pin_n <= 1'b1;
         repeat (4) @(posedge clk);
         rd(OFF_CTL);
         check("abort_ctl", q, ctl_word(1'b0, 1'b1, 1'b0));
         rd(OFF_FLAG);
         check("abort_flag", q, 32'h00000004);
         rd(OFF_DATA);
         check("abort_data", q, {24'h000000, d});
         rd(OFF_ADDR);
         check("abort_addr", q, {24'h000000, a});
         wr(OFF_CLR, 32'h00000007);
         ee_write(a, d);
         wait_idle();
         ee_read(a);
         check("retry_byte", q, {24'h000000, d});
      end
      check("hresp", {31'h00000000, hresp}, 32'h00000000);
      check("hreadyout", {31'h00000000, hreadyout}, 32'h00000001);
      close_out();
   end
endmodule
